// file: afs_regs.svh
// register offsets, field positions, reset values for the fault bank
`ifndef AFS_REGS_SVH
`define AFS_REGS_SVH

`define AFS_ADDR_CHANNEL_FAULT_STATUS     8'h70
`define AFS_ADDR_SYS_FAULT      8'h71
`define AFS_ADDR_TSD_STATUS     8'h72
`define AFS_ADDR_TWARN_STATUS   8'h73
`define AFS_ADDR_REPORT_MASK    8'h74
`define AFS_ADDR_LATCH_CTRL     8'h75
`define AFS_ADDR_RECOVERY_CTRL  8'h76
`define AFS_ADDR_FAULT_RESET    8'h78

`define AFS_RST_REPORT_MASK     8'h00
`define AFS_RST_LATCH_CTRL      8'hF8
`define AFS_RST_RECOVERY_CTRL   8'h00
`define AFS_RST_FAULT_RESET     8'h00

// channel fault status
`define AFS_BIT_LEFT_DC         3
`define AFS_BIT_RIGHT_DC        2
`define AFS_BIT_LEFT_OC         1
`define AFS_BIT_RIGHT_OC        0
// system fault status
`define AFS_BIT_CRC_ERR         7
`define AFS_BIT_COEFF_FAIL      6
`define AFS_BIT_CLK_FAULT       2
`define AFS_BIT_PS_OV           1
`define AFS_BIT_PS_UV           0
// thermal status registers
`define AFS_BIT_TSD             0
`define AFS_BIT_TWARN           2
// report mask
`define AFS_BIT_MASK_TSD        7
`define AFS_BIT_MASK_CORE_UV    6
`define AFS_BIT_MASK_CORE_OV    5
`define AFS_BIT_MASK_CLK        4
`define AFS_BIT_MASK_PS_UV      3
`define AFS_BIT_MASK_PS_OV      2
`define AFS_BIT_DC_ERROR_MASK         1
`define AFS_BIT_OVERCURRENT_MASK         0
// latch control
`define AFS_BIT_CLK_LATCH_EN    5
`define AFS_BIT_TSD_LATCH_EN    4
`define AFS_BIT_TWARN_LATCH_EN  3
`define AFS_BIT_MASK_TWARN      2
// recovery control
`define AFS_BIT_DET_HOLD        7
`define AFS_BIT_AUTO_RECOVER    4
// fault reset command
`define AFS_BIT_ANALOG_CLEAR    7

`define AFS_SYNC_STAGES         3

`endif

// file: afs_pkg.sv
// shared types of the fault bank
`default_nettype none
package afs_pkg;

	typedef logic [7:0] afs_byte_type;

	// order of the live fault inputs inside the synchroniser vector
	typedef enum {
		AFS_IN_LEFT_DC,
		AFS_IN_RIGHT_DC,
		AFS_IN_LEFT_OC,
		AFS_IN_RIGHT_OC,
		AFS_IN_PS_OV,
		AFS_IN_PS_UV,
		AFS_IN_CLK_FAULT,
		AFS_IN_TSD,
		AFS_IN_TWARN,
		AFS_IN_CORE_UV,
		AFS_IN_CORE_OV,
		AFS_IN_CLK_DETECT,
		AFS_IN_COUNT
	} afs_input_type;

endpackage
`default_nettype wire

// file: afs_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module afs_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic             clk_en,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// ------------------------------------------------------------
	// capture chain
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else if (clk_en) begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// ------------------------------------------------------------
	// accept a bit only once stages two and three agree
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sync_out <= '0;
		end else if (clk_en) begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					sync_out[i] <= stage3[i];
				end
			end
		end
	end

endmodule
`default_nettype wire

// file: afs_fault_bank.sv
// fault status, mask and latch register bank of the amplifier
//
// Contract
// - dc flags: left bit 3, right bit 2 of channel status, reset zero
// - overcurrent flags: left bit 1, right bit 0 of channel status
// - system status bit 7 sets on memory crc check failure
// - system status bit 6 sets when last coefficient write failed
// - thermal shutdown flag at bit 0, other bits of register zero
// - thermal warning flag at bit 2 of warning status register
// - mask bit 7 suppresses thermal shutdown report, reset zero
// - mask bit 6 hides core undervoltage, bit 5 core overvoltage
// - mask bit 4 suppresses clock fault report, reset zero
// - mask bit 3 hides supply undervoltage, bit 2 supply overvoltage
// - mask bit 1 hides dc faults, bit 0 overcurrent faults
// - latch control bit 5 (reset one) latches clock fault
// - latch control bit 4 (reset one) latches thermal shutdown
// - latch control bit 3 (reset one) latches thermal warning
// - latch control bit 2 suppresses warning report, reset zero
// - recovery bit 7 holds clock detection status, reset zero
// - recovery bit 4 enables thermal shutdown auto recovery
// - writing one to clear bit 7 clears all analog fault flags
`timescale 1ns/1ps
`default_nettype none
`include "afs_regs.svh"
module afs_fault_bank (
	input  wire logic                 clk_sys,
	input  wire logic                 reset,
	input  wire logic                 clk_en,
	input  wire logic [7:0]           reg_addr,
	input  wire afs_pkg::afs_byte_type reg_wdata,
	input  wire logic                 reg_write,
	input  wire logic                 reg_read,
	output var  afs_pkg::afs_byte_type reg_rdata,
	output var  logic                 reg_rvalid,
	input  wire logic                 left_dc_error,
	input  wire logic                 right_dc_error,
	input  wire logic                 left_overcurrent,
	input  wire logic                 right_overcurrent,
	input  wire logic                 power_stage_overvoltage,
	input  wire logic                 power_stage_undervoltage,
	input  wire logic                 clock_error,
	input  wire logic                 thermal_shutdown,
	input  wire logic                 thermal_warning,
	input  wire logic                 core_undervoltage,
	input  wire logic                 core_overvoltage,
	input  wire logic                 clock_detect,
	input  wire logic                 otp_crc_error,
	input  wire logic                 coeff_write_fail,
	output var  logic                 fault_report,
	output var  logic                 clock_detect_status
);

	localparam int NIN = int'(afs_pkg::AFS_IN_COUNT);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	afs_pkg::afs_byte_type report_mask;
	afs_pkg::afs_byte_type latch_control;
	afs_pkg::afs_byte_type recovery_control;
	afs_pkg::afs_byte_type fault_reset_spare;
	logic [NIN-1:0]        raw_in;
	logic [NIN-1:0]        live;
	logic                  left_dc_flag;
	logic                  right_dc_flag;
	logic                  left_overcurrent_flag;
	logic                  right_overcurrent_flag;
	logic                  power_stage_overvoltage_flag;
	logic                  power_stage_undervoltage_flag;
	logic                  clock_error_flag;
	logic                  thermal_shutdown_flag;
	logic                  thermal_warning_flag;
	logic                  core_undervoltage_flag;
	logic                  core_overvoltage_flag;
	logic                  crc_error_flag;
	logic                  coeff_write_fail_flag;
	logic                  analog_clear;
	logic                  wr_fault_reset;
	logic                  tsd_hold;
	logic                  next_fault_report;
	afs_pkg::afs_byte_type next_rdata;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// set wins: a live condition in the clear cycle keeps the flag
	function automatic logic next_flag(
		input logic held,
		input logic cond,
		input logic hold_en,
		input logic clr
	);
		next_flag = cond | (held & hold_en & ~clr);
	endfunction

	function automatic logic addr_hit(
		input logic [7:0] addr,
		input logic [7:0] target
	);
		addr_hit = (addr == target);
	endfunction

	// ------------------------------------------------------------
	// detector inputs cross in from the analog side
	// ------------------------------------------------------------
	always_comb begin
		raw_in = '0;
		raw_in[afs_pkg::AFS_IN_LEFT_DC]    = left_dc_error;
		raw_in[afs_pkg::AFS_IN_RIGHT_DC]   = right_dc_error;
		raw_in[afs_pkg::AFS_IN_LEFT_OC]    = left_overcurrent;
		raw_in[afs_pkg::AFS_IN_RIGHT_OC]   = right_overcurrent;
		raw_in[afs_pkg::AFS_IN_PS_OV]      = power_stage_overvoltage;
		raw_in[afs_pkg::AFS_IN_PS_UV]      = power_stage_undervoltage;
		raw_in[afs_pkg::AFS_IN_CLK_FAULT]  = clock_error;
		raw_in[afs_pkg::AFS_IN_TSD]        = thermal_shutdown;
		raw_in[afs_pkg::AFS_IN_TWARN]      = thermal_warning;
		raw_in[afs_pkg::AFS_IN_CORE_UV]    = core_undervoltage;
		raw_in[afs_pkg::AFS_IN_CORE_OV]    = core_overvoltage;
		raw_in[afs_pkg::AFS_IN_CLK_DETECT] = clock_detect;
	end

	afs_sync #(
		.WIDTH(NIN)
	) u_sync (
		.clk_sys (clk_sys),
		.reset   (reset),
		.clk_en  (clk_en),
		.async_in(raw_in),
		.sync_out(live)
	);

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	assign wr_fault_reset = reg_write
		& addr_hit(reg_addr, `AFS_ADDR_FAULT_RESET);
	assign analog_clear = wr_fault_reset
		& reg_wdata[`AFS_BIT_ANALOG_CLEAR];

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			report_mask <= `AFS_RST_REPORT_MASK;
		end else if (clk_en && reg_write
			&& addr_hit(reg_addr, `AFS_ADDR_REPORT_MASK)) begin
			report_mask <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			latch_control <= `AFS_RST_LATCH_CTRL;
		end else if (clk_en && reg_write
			&& addr_hit(reg_addr, `AFS_ADDR_LATCH_CTRL)) begin
			latch_control <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			recovery_control <= `AFS_RST_RECOVERY_CTRL;
		end else if (clk_en && reg_write
			&& addr_hit(reg_addr, `AFS_ADDR_RECOVERY_CTRL)) begin
			recovery_control <= reg_wdata;
		end
	end

	// spare bits of the clear register keep their written value
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			fault_reset_spare <= `AFS_RST_FAULT_RESET;
		end else if (clk_en && wr_fault_reset) begin
			fault_reset_spare <= {1'b0, reg_wdata[6:0]};
		end
	end

	// ------------------------------------------------------------
	// analog fault flags
	// ------------------------------------------------------------
	// dc and overcurrent always hold; a glitch must not vanish unseen
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			left_dc_flag           <= 1'b0;
			right_dc_flag          <= 1'b0;
			left_overcurrent_flag  <= 1'b0;
			right_overcurrent_flag <= 1'b0;
		end else if (clk_en) begin
			left_dc_flag <= next_flag(left_dc_flag,
				live[afs_pkg::AFS_IN_LEFT_DC], 1'b1, analog_clear);
			right_dc_flag <= next_flag(right_dc_flag,
				live[afs_pkg::AFS_IN_RIGHT_DC], 1'b1, analog_clear);
			left_overcurrent_flag <= next_flag(left_overcurrent_flag,
				live[afs_pkg::AFS_IN_LEFT_OC], 1'b1, analog_clear);
			right_overcurrent_flag <= next_flag(right_overcurrent_flag,
				live[afs_pkg::AFS_IN_RIGHT_OC], 1'b1, analog_clear);
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			power_stage_overvoltage_flag  <= 1'b0;
			power_stage_undervoltage_flag <= 1'b0;
			core_undervoltage_flag        <= 1'b0;
			core_overvoltage_flag         <= 1'b0;
		end else if (clk_en) begin
			power_stage_overvoltage_flag <= next_flag(
				power_stage_overvoltage_flag,
				live[afs_pkg::AFS_IN_PS_OV], 1'b1, analog_clear);
			power_stage_undervoltage_flag <= next_flag(
				power_stage_undervoltage_flag,
				live[afs_pkg::AFS_IN_PS_UV], 1'b1, analog_clear);
			core_undervoltage_flag <= next_flag(core_undervoltage_flag,
				live[afs_pkg::AFS_IN_CORE_UV], 1'b1, analog_clear);
			core_overvoltage_flag <= next_flag(core_overvoltage_flag,
				live[afs_pkg::AFS_IN_CORE_OV], 1'b1, analog_clear);
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			clock_error_flag <= 1'b0;
		end else if (clk_en) begin
			clock_error_flag <= next_flag(clock_error_flag,
				live[afs_pkg::AFS_IN_CLK_FAULT],
				latch_control[`AFS_BIT_CLK_LATCH_EN],
				analog_clear);
		end
	end

	// auto recovery lets the flag drop as soon as the die cools
	assign tsd_hold = latch_control[`AFS_BIT_TSD_LATCH_EN]
		& ~recovery_control[`AFS_BIT_AUTO_RECOVER];

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			thermal_shutdown_flag <= 1'b0;
			thermal_warning_flag  <= 1'b0;
		end else if (clk_en) begin
			thermal_shutdown_flag <= next_flag(thermal_shutdown_flag,
				live[afs_pkg::AFS_IN_TSD], tsd_hold, analog_clear);
			thermal_warning_flag <= next_flag(thermal_warning_flag,
				live[afs_pkg::AFS_IN_TWARN],
				latch_control[`AFS_BIT_TWARN_LATCH_EN],
				analog_clear);
		end
	end

	// ------------------------------------------------------------
	// digital fault flags follow their sources, not the clear
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			crc_error_flag        <= 1'b0;
			coeff_write_fail_flag <= 1'b0;
		end else if (clk_en) begin
			crc_error_flag        <= otp_crc_error;
			coeff_write_fail_flag <= coeff_write_fail;
		end
	end

	// ------------------------------------------------------------
	// clock detection status
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			clock_detect_status <= 1'b0;
		end else if (clk_en) begin
			clock_detect_status <= next_flag(clock_detect_status,
				live[afs_pkg::AFS_IN_CLK_DETECT],
				recovery_control[`AFS_BIT_DET_HOLD],
				analog_clear);
		end
	end

	// ------------------------------------------------------------
	// fault report output
	// ------------------------------------------------------------
	always_comb begin
		next_fault_report = 1'b0;
		if (thermal_shutdown_flag
			&& !report_mask[`AFS_BIT_MASK_TSD]) begin
			next_fault_report = 1'b1;
		end
		if ((core_undervoltage_flag
			&& !report_mask[`AFS_BIT_MASK_CORE_UV])
			|| (core_overvoltage_flag
			&& !report_mask[`AFS_BIT_MASK_CORE_OV])) begin
			next_fault_report = 1'b1;
		end
		if (clock_error_flag
			&& !report_mask[`AFS_BIT_MASK_CLK]) begin
			next_fault_report = 1'b1;
		end
		if ((power_stage_undervoltage_flag
			&& !report_mask[`AFS_BIT_MASK_PS_UV])
			|| (power_stage_overvoltage_flag
			&& !report_mask[`AFS_BIT_MASK_PS_OV])) begin
			next_fault_report = 1'b1;
		end
		if ((left_dc_flag || right_dc_flag)
			&& !report_mask[`AFS_BIT_DC_ERROR_MASK]) begin
			next_fault_report = 1'b1;
		end
		if ((left_overcurrent_flag || right_overcurrent_flag)
			&& !report_mask[`AFS_BIT_OVERCURRENT_MASK]) begin
			next_fault_report = 1'b1;
		end
		if (thermal_warning_flag
			&& !latch_control[`AFS_BIT_MASK_TWARN]) begin
			next_fault_report = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			fault_report <= 1'b0;
		end else if (clk_en) begin
			fault_report <= next_fault_report;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		case (reg_addr)
			`AFS_ADDR_CHANNEL_FAULT_STATUS: begin
				next_rdata[`AFS_BIT_LEFT_DC]  = left_dc_flag;
				next_rdata[`AFS_BIT_RIGHT_DC] = right_dc_flag;
				next_rdata[`AFS_BIT_LEFT_OC]  = left_overcurrent_flag;
				next_rdata[`AFS_BIT_RIGHT_OC] = right_overcurrent_flag;
			end
			`AFS_ADDR_SYS_FAULT: begin
				next_rdata[`AFS_BIT_CRC_ERR]    = crc_error_flag;
				next_rdata[`AFS_BIT_COEFF_FAIL] = coeff_write_fail_flag;
				next_rdata[`AFS_BIT_CLK_FAULT]  = clock_error_flag;
				next_rdata[`AFS_BIT_PS_OV] = power_stage_overvoltage_flag;
				next_rdata[`AFS_BIT_PS_UV] = power_stage_undervoltage_flag;
			end
			`AFS_ADDR_TSD_STATUS: begin
				next_rdata[`AFS_BIT_TSD] = thermal_shutdown_flag;
			end
			`AFS_ADDR_TWARN_STATUS: begin
				next_rdata[`AFS_BIT_TWARN] = thermal_warning_flag;
			end
			`AFS_ADDR_REPORT_MASK: begin
				next_rdata = report_mask;
			end
			`AFS_ADDR_LATCH_CTRL: begin
				next_rdata = latch_control;
			end
			`AFS_ADDR_RECOVERY_CTRL: begin
				next_rdata = recovery_control;
			end
			`AFS_ADDR_FAULT_RESET: begin
				// clear bit is write-only and always reads zero
				next_rdata = fault_reset_spare;
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else if (clk_en) begin
			reg_rvalid <= reg_read;
			if (reg_read) begin
				reg_rdata <= next_rdata;
			end
		end
	end

endmodule
`default_nettype wire

// file: afs_fault_bank_checker.sv
// assertion checker for the fault register bank
`timescale 1ns/1ps
`default_nettype none
module afs_fault_bank_checker (
	input wire logic                  clk_sys,
	input wire logic                  reset,
	input wire logic                  clk_en,
	input wire logic [7:0]            reg_addr,
	input wire afs_pkg::afs_byte_type reg_wdata,
	input wire logic                  reg_write,
	input wire logic                  reg_read,
	input wire afs_pkg::afs_byte_type reg_rdata,
	input wire logic                  reg_rvalid
);
	logic rd_take;
	logic wr_take;
	assign rd_take = reg_read && clk_en;
	assign wr_take = reg_write && clk_en;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_rvalid_one_cycle: assert property (
		$past(clk_en) |-> reg_rvalid == $past(reg_read))
		else $error("read valid out of step");
	a_chan_reserved: assert property (
		$past(rd_take) && $past(reg_addr) == 8'h70 |-> reg_rdata[7:4] == 4'h0)
		else $error("channel status reserved bits set");
	a_sys_reserved: assert property (
		$past(rd_take) && $past(reg_addr) == 8'h71 |-> reg_rdata[5:3] == 3'h0)
		else $error("system status reserved bits set");
	a_tsd_reserved: assert property (
		$past(rd_take) && $past(reg_addr) == 8'h72 |-> reg_rdata[7:1] == 7'h00)
		else $error("shutdown status reserved bits set");
	a_warn_reserved: assert property (
		$past(rd_take) && $past(reg_addr) == 8'h73 |-> (reg_rdata & 8'hFB) == 0)
		else $error("warning status reserved bits set");
	a_clear_reads_zero: assert property (
		$past(rd_take) && $past(reg_addr) == 8'h78 |-> !reg_rdata[7])
		else $error("clear command bit reads back");
	a_mask_readback: assert property (
		$past(rd_take) && $past(reg_addr) == 8'h74 && $past(wr_take, 2)
		&& $past(reg_addr, 2) == 8'h74 |-> reg_rdata == $past(reg_wdata, 2))
		else $error("mask register lost written value");
	a_latch_readback: assert property (
		$past(rd_take) && $past(reg_addr) == 8'h75 && $past(wr_take, 2)
		&& $past(reg_addr, 2) == 8'h75 |-> reg_rdata == $past(reg_wdata, 2))
		else $error("latch control lost written value");
	a_recover_readback: assert property (
		$past(rd_take) && $past(reg_addr) == 8'h76 && $past(wr_take, 2)
		&& $past(reg_addr, 2) == 8'h76 |-> reg_rdata == $past(reg_wdata, 2))
		else $error("recovery control lost written value");
endmodule
bind afs_fault_bank afs_fault_bank_checker i_chk (.clk_sys(clk_sys),
	.reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
`default_nettype wire

// file: afs_fault_bank_tb_top.sv
// self-checking bench for the fault register bank
`timescale 1ns/1ps
`default_nettype none
module afs_fault_bank_tb_top;
	typedef afs_pkg::afs_byte_type byte_t;
	logic        clk_sys;
	logic        reset;
	logic        clk_en;
	logic [7:0]  reg_addr;
	byte_t       reg_wdata;
	logic        reg_write;
	logic        reg_read;
	byte_t       reg_rdata;
	logic        reg_rvalid;
	logic [11:0] flt;
	logic        otp_crc_error;
	logic        coeff_write_fail;
	logic        fault_report;
	logic        clock_detect_status;
	int          bad_count;
	int          samples_checked;
	byte_t       d;
	byte_t       mv;
	// ----------------------------------------
	// fault order: dc l/r, oc l/r, ps ov/uv, clk, tsd, warn, core uv/ov
	// ----------------------------------------
	byte_t sa [11] = '{8'h70, 8'h70, 8'h70, 8'h70, 8'h71, 8'h71, 8'h71,
		8'h72, 8'h73, 8'h00, 8'h00};
	byte_t sv [11] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h02, 8'h01, 8'h04,
		8'h01, 8'h04, 8'h00, 8'h00};
	byte_t ma [11] = '{8'h74, 8'h74, 8'h74, 8'h74, 8'h74, 8'h74, 8'h74,
		8'h74, 8'h75, 8'h74, 8'h74};
	byte_t mk [11] = '{8'h02, 8'h02, 8'h01, 8'h01, 8'h04, 8'h08, 8'h10,
		8'h80, 8'h04, 8'h40, 8'h20};
	byte_t rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF8, 8'h00,
		8'h00, 8'h00};
	byte_t ro [5] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h77};
	byte_t rw [4] = '{8'h74, 8'h75, 8'h76, 8'h78};
	int    li [3] = '{6, 8, 7};
	byte_t la [3] = '{8'h75, 8'h75, 8'h76};
	byte_t lv [3] = '{8'hC0, 8'hC0, 8'h10};
	byte_t lr [3] = '{8'hF8, 8'hF8, 8'h00};

	afs_fault_bank i_dut (
		.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.left_dc_error(flt[0]), .right_dc_error(flt[1]),
		.left_overcurrent(flt[2]), .right_overcurrent(flt[3]),
		.power_stage_overvoltage(flt[4]), .power_stage_undervoltage(flt[5]),
		.clock_error(flt[6]), .thermal_shutdown(flt[7]),
		.thermal_warning(flt[8]), .core_undervoltage(flt[9]),
		.core_overvoltage(flt[10]), .clock_detect(flt[11]),
		.otp_crc_error(otp_crc_error), .coeff_write_fail(coeff_write_fail),
		.fault_report(fault_report),
		.clock_detect_status(clock_detect_status));

	initial clk_sys = 1'b0;
	always #20 clk_sys = ~clk_sys;

	// ----------------------------------------
	// compare, bus and closing tasks
	// ----------------------------------------
	task automatic cmp(input byte_t got, input byte_t exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk(ref logic s, input logic e);
		#1;
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, s, e);
		end
		@(posedge clk_sys);
	endtask
	task automatic wr(input byte_t a, input byte_t v);
		// back-to-back writes: let an edge pass, never re-raise in one step
		if (reg_write === 1'b1) begin
			@(posedge clk_sys);
		end
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask
	// answer arrives on the edge that takes the strobe
	task automatic rd(input byte_t a, input byte_t e);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1;
		chk(reg_rvalid, 1'b1);
		cmp(reg_rdata, e);
	endtask
	// synchroniser plus filter needs four edges, flag and report two more
	task automatic settle;
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic end_sim;
		$display("checked %0d errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (50000) @(posedge clk_sys);
		bad_count++;
		end_sim();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(36997));
		{reset, clk_en, reg_write, reg_read} = 4'hC;
		{reg_addr, reg_wdata, flt} = '0;
		{otp_crc_error, coeff_write_fail} = 2'h0;
		bad_count = 0;
		samples_checked = 0;
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		for (int k = 0; k < 9; k++)
			rd(8'h70 + byte_t'(k), rv[k]);
		for (int k = 0; k < 5; k++) begin
			wr(ro[k], byte_t'($urandom));
			rd(ro[k], 8'h00);
		end
		for (int k = 0; k < 12; k++) begin
			d = byte_t'($urandom);
			wr(rw[k % 4], d);
			rd(rw[k % 4], (k % 4 == 3) ? (d & 8'h7F) : d);
		end
		for (int k = 0; k < 4; k++)
			wr(rw[k], rv[k + 4]);
		// every analog fault, first reported, then masked
		for (int i = 0; i < 11; i++) begin
			for (int m = 0; m < 2; m++) begin
				mv = (ma[i] == 8'h75) ? 8'hF8 : 8'h00;
				wr(ma[i], mv | ((m == 1) ? mk[i] : 8'h00));
				flt[i] <= 1'b1;
				settle();
				chk(fault_report, m == 0);
				if (sa[i] != 0) rd(sa[i], sv[i]);
				flt[i] <= 1'b0;
				settle();
				chk(fault_report, m == 0);
				if (sa[i] != 0) rd(sa[i], sv[i]);
				wr(8'h78, 8'h80);
				settle();
				chk(fault_report, 1'b0);
				if (sa[i] != 0) rd(sa[i], 8'h00);
				wr(ma[i], mv);
			end
		end
		// latch off or auto recovery on: flags follow the live level
		for (int k = 0; k < 3; k++) begin
			wr(la[k], lv[k]);
			flt[li[k]] <= 1'b1;
			settle();
			rd(sa[li[k]], sv[li[k]]);
			flt[li[k]] <= 1'b0;
			settle();
			rd(sa[li[k]], 8'h00);
			wr(la[k], lr[k]);
		end
		// clear while a condition persists must not drop it
		flt[0] <= 1'b1;
		{otp_crc_error, coeff_write_fail} <= 2'h3;
		settle();
		wr(8'h78, 8'h80);
		settle();
		rd(8'h70, 8'h08);
		rd(8'h71, 8'hC0);
		flt[0] <= 1'b0;
		{otp_crc_error, coeff_write_fail} <= 2'h0;
		// live level must have dropped, or the set wins over the clear
		settle();
		wr(8'h78, 8'h80);
		settle();
		rd(8'h70, 8'h00);
		for (int m = 0; m < 2; m++) begin
			wr(8'h76, (m == 1) ? 8'h80 : 8'h00);
			flt[11] <= 1'b1;
			settle();
			chk(clock_detect_status, 1'b1);
			flt[11] <= 1'b0;
			settle();
			chk(clock_detect_status, m == 1);
			wr(8'h78, 8'h80);
			settle();
			chk(clock_detect_status, 1'b0);
		end
		wr(8'h76, 8'h00);
		// frozen clock enable drops the write
		clk_en <= 1'b0;
		wr(8'h74, 8'hFF);
		clk_en <= 1'b1;
		rd(8'h74, 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire
